// *** pkg/fcpwm_pkg.sv ***
// Purpose: Shared constants for the four channel PWM block
// Assumes: 8-bit register port, byte addresses as printed
// Notes: Control, routing and interrupt registers sit at chosen addresses
package fcpwm_pkg;
    localparam int CHANS = 4;
    localparam int DUTY_W = 10;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_CH2_HI = 8'hb1;
    localparam logic [7:0] ADDR_CH2_LO = 8'hb2;
    localparam logic [7:0] ADDR_CH3_HI = 8'hb3;
    localparam logic [7:0] ADDR_CH3_LO = 8'hb4;
    localparam logic [7:0] ADDR_CH0_HI = 8'hbc;
    localparam logic [7:0] ADDR_CH0_LO = 8'hbd;
    localparam logic [7:0] ADDR_CH1_HI = 8'hbe;
    localparam logic [7:0] ADDR_CH1_LO = 8'hbf;
    localparam logic [7:0] ADDR_MAX_HI = 8'hce;
    localparam logic [7:0] ADDR_MAX_LO = 8'hcf;
    localparam logic [7:0] ADDR_CTRL = 8'hb5;
    localparam logic [7:0] ADDR_ROUTE = 8'h91;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hb6;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hb7;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int IDLE_BIT = 7;
    localparam int CSEL_LSB = 5;
    localparam int ROUTE_BIT = 1;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_MAX_LO = 8'hff;
    // ****************************************
    // Clock select codes
    // ****************************************
    localparam logic [2:0] CS_DIV1 = 3'h0;
    localparam logic [2:0] CS_DIV2 = 3'h1;
    localparam logic [2:0] CS_DIV4 = 3'h2;
    localparam logic [2:0] CS_DIV6 = 3'h3;
    localparam logic [2:0] CS_DIV8 = 3'h4;
    localparam logic [2:0] CS_DIV12 = 3'h5;
    localparam logic [2:0] CS_T0OVF = 3'h6;
    localparam logic [2:0] CS_T0EXT = 3'h7;
endpackage

// *** rtl/fcpwm_clkgen.sv ***
// Purpose: PWM clock enable generator
// Assumes: Timer inputs are synchronous one-cycle pulses or levels
// Notes: Emits a one-cycle tick per selected PWM clock
`timescale 1ns/1ps
`default_nettype none
module fcpwm_clkgen (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Selection and sources
    input wire logic [2:0] sel,
    input wire logic t0_ovf,
    input wire logic t0_ext,
    // Tick out
    output logic tick
);
    import fcpwm_pkg::*;

    logic [3:0] cnt_reg, cnt_next;
    logic ext_reg, ext_next;
    logic tick_reg, tick_next;
    logic [3:0] last;

    always_comb begin
        case (sel)
            CS_DIV2: last = 4'h1;
            CS_DIV4: last = 4'h3;
            CS_DIV6: last = 4'h5;
            CS_DIV8: last = 4'h7;
            CS_DIV12: last = 4'hb;
            default: last = 4'h0;
        endcase
        ext_next = t0_ext;
        cnt_next = (cnt_reg >= last) ? 4'h0 : cnt_reg + 4'h1;
        if (sel == CS_T0OVF) begin // R09
            tick_next = t0_ovf;
        end else if (sel == CS_T0EXT) begin // R09
            // Falling edge of the external pin counts, as timer 0 does
            tick_next = ext_reg & ~t0_ext;
        end else begin
            tick_next = (cnt_reg >= last); // R09
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
            ext_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ext_reg <= ext_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule
`default_nettype wire

// *** rtl/fcpwm_top.sv ***
// Purpose: Four channel PWM with shared period counter
// Assumes: Register port address, wdata, write and read strobes
// Notes: Read data valid the cycle after the read strobe
// Function
// R01: Each channel outputs its waveform only while its enable bit is one.
// R02: Bit 7 of each high duty byte selects idle polarity; bits 6:2 unused.
// R03: Idle polarity zero rests low, one rests high.
// R04: Duty is 10 bits; high byte bits 1:0, low byte bits 7:0.
// R05: Shared 10-bit period maximum split over high and low registers.
// R06: Period counter advances once per PWM clock from zero upward.
// R07: Counter at maximum counts as overflow and restarts from zero.
// R08: Period is max plus one clocks; leading active pulse lasts duty clocks.
// R09: Three-bit select picks oscillator divisors or timer 0 sources.
// R10: Routing bit steers outputs to port 4 when zero, port 2 when one.
// R11: Period maximum low byte resets to all ones.
// R12: Four outputs and one interrupt source.
`timescale 1ns/1ps
`default_nettype none
module fcpwm_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Timer 0 sources
    input wire logic t0_ovf,
    input wire logic t0_ext,
    // Pins
    output logic [fcpwm_pkg::CHANS-1:0] port4_pwm,
    output logic [fcpwm_pkg::CHANS-1:0] port2_pwm,
    output logic [fcpwm_pkg::CHANS-1:0] pwm_output_pin,
    // Interrupt
    output logic pwm_irq
);
    import fcpwm_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rsync_reg;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rsync_reg <= 2'b00;
        end else begin
            rsync_reg <= {rsync_reg[0], 1'b1};
        end
    end
    assign rst_n = rsync_reg[1];

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] hi_reg [CHANS], hi_next [CHANS];
    logic [7:0] lo_reg [CHANS], lo_next [CHANS];
    logic [1:0] max_hi_reg, max_hi_next;
    logic [7:0] max_lo_reg, max_lo_next;
    logic [2:0] pwm_clock_select;
    logic [CHANS-1:0] chan_on;
    logic [7:0] pwm_control_reg, pwm_control_next;
    logic pwm_pin_route, route_next;
    logic irq_stat_reg, irq_stat_next;
    logic irq_mask_reg, irq_mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [DUTY_W-1:0] cnt_reg, cnt_next;
    logic [CHANS-1:0] out_reg, out_next;
    logic [CHANS-1:0] p4_reg, p4_next, p2_reg, p2_next;
    logic irq_reg, irq_next;
    logic tick;
    logic [DUTY_W-1:0] period_max_value;
    logic [DUTY_W-1:0] duty_value [CHANS];
    logic [CHANS-1:0] idle_level_select;
    logic [1:0] ch_idx;
    logic ch_hit, ch_hi;
    logic wrap;

    assign pwm_clock_select = pwm_control_reg[CSEL_LSB+2:CSEL_LSB];
    assign chan_on = pwm_control_reg[CHANS-1:0];
    assign period_max_value = {max_hi_reg, max_lo_reg}; // R05

    // Channel address lookup shared by read and write decode
    always_comb begin
        ch_hit = 1'b1;
        ch_hi = 1'b0;
        ch_idx = 2'd0;
        if (reg_addr == ADDR_CH0_HI) begin
            ch_hi = 1'b1;
        end else if (reg_addr == ADDR_CH0_LO) begin
            ch_idx = 2'd0;
        end else if (reg_addr == ADDR_CH1_HI) begin
            ch_idx = 2'd1;
            ch_hi = 1'b1;
        end else if (reg_addr == ADDR_CH1_LO) begin
            ch_idx = 2'd1;
        end else if (reg_addr == ADDR_CH2_HI) begin
            ch_idx = 2'd2;
            ch_hi = 1'b1;
        end else if (reg_addr == ADDR_CH2_LO) begin
            ch_idx = 2'd2;
        end else if (reg_addr == ADDR_CH3_HI) begin
            ch_idx = 2'd3;
            ch_hi = 1'b1;
        end else if (reg_addr == ADDR_CH3_LO) begin
            ch_idx = 2'd3;
        end else begin
            ch_hit = 1'b0;
        end
    end

    // ****************************************
    // Register write and read
    // ****************************************
    always_comb begin
        for (int i = 0; i < CHANS; i++) begin
            hi_next[i] = hi_reg[i];
            lo_next[i] = lo_reg[i];
        end
        max_hi_next = max_hi_reg;
        max_lo_next = max_lo_reg;
        pwm_control_next = pwm_control_reg;
        route_next = pwm_pin_route;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        rdata_next = 8'h00;
        if (reg_wr) begin
            if (ch_hit && ch_hi) begin
                // Only polarity and duty bits 9:8 are stored
                hi_next[ch_idx] = reg_wdata & 8'h83; // R02 R04
            end else if (ch_hit) begin
                lo_next[ch_idx] = reg_wdata; // R04
            end else if (reg_addr == ADDR_MAX_HI) begin
                max_hi_next = reg_wdata[1:0]; // R05
            end else if (reg_addr == ADDR_MAX_LO) begin
                max_lo_next = reg_wdata; // R05
            end else if (reg_addr == ADDR_CTRL) begin
                pwm_control_next = reg_wdata & 8'hef;
            end else if (reg_addr == ADDR_ROUTE) begin
                route_next = reg_wdata[ROUTE_BIT]; // R10
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                irq_mask_next = reg_wdata[0];
            end else if (reg_addr == ADDR_IRQ_STAT && reg_wdata[0]) begin
                irq_stat_next = 1'b0;
            end
        end
        if (reg_rd) begin
            if (ch_hit && ch_hi) begin
                rdata_next = hi_reg[ch_idx];
            end else if (ch_hit) begin
                rdata_next = lo_reg[ch_idx];
            end else if (reg_addr == ADDR_MAX_HI) begin
                rdata_next = {6'h00, max_hi_reg};
            end else if (reg_addr == ADDR_MAX_LO) begin
                rdata_next = max_lo_reg;
            end else if (reg_addr == ADDR_CTRL) begin
                rdata_next = pwm_control_reg;
            end else if (reg_addr == ADDR_ROUTE) begin
                rdata_next = {6'h00, pwm_pin_route, 1'b0};
            end else if (reg_addr == ADDR_IRQ_STAT) begin
                rdata_next = {7'h00, irq_stat_reg};
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                rdata_next = {7'h00, irq_mask_reg};
            end
        end
        // Overflow sets the flag; set wins over a same-cycle clear
        if (wrap) begin
            irq_stat_next = 1'b1; // R12
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANS; i++) begin
                hi_reg[i] <= RST_ZERO;
                lo_reg[i] <= RST_ZERO;
            end
            max_hi_reg <= 2'h0;
            max_lo_reg <= RST_MAX_LO; // R11
            pwm_control_reg <= RST_ZERO;
            pwm_pin_route <= 1'b0;
            irq_stat_reg <= 1'b0;
            irq_mask_reg <= 1'b0;
            rdata_reg <= RST_ZERO;
        end else begin
            for (int i = 0; i < CHANS; i++) begin
                hi_reg[i] <= hi_next[i];
                lo_reg[i] <= lo_next[i];
            end
            max_hi_reg <= max_hi_next;
            max_lo_reg <= max_lo_next;
            pwm_control_reg <= pwm_control_next;
            pwm_pin_route <= route_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // PWM clock and period counter
    // ****************************************
    fcpwm_clkgen i_fcpwm_clkgen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sel(pwm_clock_select),
        .t0_ovf(t0_ovf),
        .t0_ext(t0_ext),
        .tick(tick)
    );

    // Counter only runs while some channel is on, so a fresh enable starts a period
    assign wrap = tick && (|chan_on) && (cnt_reg >= period_max_value); // R07
    always_comb begin
        cnt_next = cnt_reg;
        if (!(|chan_on)) begin
            cnt_next = '0;
        end else if (wrap) begin
            cnt_next = '0; // R07
        end else if (tick) begin
            cnt_next = cnt_reg + 10'h001; // R06
        end
    end

    // ****************************************
    // Channel outputs
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < CHANS; g++) begin : g_ch
            assign duty_value[g] = {hi_reg[g][1:0], lo_reg[g]}; // R04
            assign idle_level_select[g] = hi_reg[g][IDLE_BIT]; // R02
            always_comb begin
                if (!chan_on[g]) begin
                    out_next[g] = idle_level_select[g]; // R01 R03
                end else if (cnt_reg < duty_value[g]) begin
                    out_next[g] = ~idle_level_select[g]; // R08
                end else begin
                    out_next[g] = idle_level_select[g]; // R08 R03
                end
                // Unselected port holds the idle level so loads stay quiet
                p4_next[g] = pwm_pin_route ? idle_level_select[g] : out_next[g]; // R10
                p2_next[g] = pwm_pin_route ? out_next[g] : idle_level_select[g]; // R10
            end
        end
    endgenerate

    assign irq_next = irq_stat_next & irq_mask_next;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            out_reg <= '0;
            p4_reg <= '0;
            p2_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            p4_reg <= p4_next;
            p2_reg <= p2_next;
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign pwm_output_pin = out_reg;
    assign port4_pwm = p4_reg;
    assign port2_pwm = p2_reg;
    assign pwm_irq = irq_reg; // R12
endmodule
`default_nettype wire

// *** tb/fcpwm_assertions.sv ***
// Purpose: Port-level checks for the four channel PWM
// Assumes: Enable, idle, route and mask bits are mirrored from writes
// Notes: Idle checks wait three quiet cycles to cover the pin pipeline
`timescale 1ns/1ps
`default_nettype none
module fcpwm_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and interrupt
    input wire logic [fcpwm_pkg::CHANS-1:0] port4_pwm,
    input wire logic [fcpwm_pkg::CHANS-1:0] port2_pwm,
    input wire logic [fcpwm_pkg::CHANS-1:0] pwm_output_pin,
    input wire logic pwm_irq
);
    import fcpwm_pkg::*;
    logic [3:0] en_m;
    logic [3:0] idle_m;
    logic mask_m;
    logic route_m;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_m <= 4'h0;
            idle_m <= 4'h0;
            mask_m <= 1'b0;
            route_m <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_CTRL: en_m <= reg_wdata[3:0];
                ADDR_ROUTE: route_m <= reg_wdata[ROUTE_BIT];
                ADDR_IRQ_MASK: mask_m <= reg_wdata[0];
                ADDR_CH0_HI: idle_m[0] <= reg_wdata[IDLE_BIT];
                ADDR_CH1_HI: idle_m[1] <= reg_wdata[IDLE_BIT];
                ADDR_CH2_HI: idle_m[2] <= reg_wdata[IDLE_BIT];
                ADDR_CH3_HI: idle_m[3] <= reg_wdata[IDLE_BIT];
                default: ;
            endcase
        end
    end
    // ****
    // Checks
    // ****
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence ctrl_rb_s;
        reg_wr && reg_addr == ADDR_CTRL ##1 reg_rd && reg_addr == ADDR_CTRL;
    endsequence
    sequence duty_rb_s;
        reg_wr && reg_addr == ADDR_CH0_HI ##1 reg_rd && reg_addr == ADDR_CH0_HI;
    endsequence
    rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    ctrl_readback_a: assert property (ctrl_rb_s |=> reg_rdata == ($past(reg_wdata, 2) & 8'hef))
        else $error("control readback wrong");
    duty_mask_a: assert property (duty_rb_s |=> reg_rdata == ($past(reg_wdata, 2) & 8'h83))
        else $error("high duty byte readback wrong");
    idle_hold_a: assert property ((en_m == 4'h0 && !reg_wr) [*3] |-> pwm_output_pin == idle_m)
        else $error("disabled pins not at idle level");
    port4_idle_a: assert property ((route_m && !reg_wr) [*3] |-> port4_pwm == idle_m)
        else $error("unrouted port four not idle");
    port2_idle_a: assert property ((!route_m && !reg_wr) [*3] |-> port2_pwm == idle_m)
        else $error("unrouted port two not idle");
    irq_masked_a: assert property (!mask_m [*2] |-> !pwm_irq)
        else $error("interrupt high while masked");
    irq_clear_a: assert property (reg_wr && reg_addr == ADDR_IRQ_STAT && reg_wdata[0] && en_m == 4'h0
        |-> ##2 !pwm_irq)
        else $error("interrupt not cleared");
endmodule
bind fcpwm_top fcpwm_assertions i_fcpwm_assertions (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port4_pwm(port4_pwm), .port2_pwm(port2_pwm), .pwm_output_pin(pwm_output_pin), .pwm_irq(pwm_irq));
`default_nettype wire

// *** tb/fcpwm_load_model.sv ***
// Purpose: Load on the PWM pins that counts high cycles
// Assumes: Pins are registered outputs sampled on the system clock
// Notes: Counts only while run is high, so windows are exact
`timescale 1ns/1ps
`default_nettype none
module fcpwm_load_model (
    // Clock and control
    input wire logic clk_sys,
    input wire logic run,
    input wire logic clear,
    // Pins and counts
    input wire logic [3:0] pin,
    output logic [3:0][15:0] high_cnt
);
    // ****
    // Counters
    // ****
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (clear)
                high_cnt[i] <= 16'h0000;
            else if (run && pin[i])
                high_cnt[i] <= high_cnt[i] + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the four channel PWM
// Assumes: Read data stands the cycle after the read strobe
// Notes: Timer 0 sources run free so every clock select can be timed
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fcpwm_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic t0_ovf = 1'b0;
    logic t0_ext = 1'b0;
    logic run = 1'b0;
    logic clear = 1'b0;
    logic [3:0] t0_cnt = 4'h0;
    logic [7:0] reg_rdata;
    logic [3:0] port4_pwm;
    logic [3:0] port2_pwm;
    logic [3:0] pwm_output_pin;
    logic pwm_irq;
    logic [3:0][15:0] high_cnt;
    logic [7:0] amap [15] = '{ADDR_CH0_HI, ADDR_CH0_LO, ADDR_CH1_HI, ADDR_CH1_LO, ADDR_CH2_HI, ADDR_CH2_LO,
        ADDR_CH3_HI, ADDR_CH3_LO, ADDR_MAX_HI, ADDR_MAX_LO, ADDR_CTRL, ADDR_ROUTE, ADDR_IRQ_STAT,
        ADDR_IRQ_MASK, 8'h00};
    int bad_count = 0;
    int checks = 0;
    always #20 clk_sys = ~clk_sys;
    fcpwm_top i_fcpwm_top (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t0_ovf(t0_ovf), .t0_ext(t0_ext),
        .port4_pwm(port4_pwm), .port2_pwm(port2_pwm), .pwm_output_pin(pwm_output_pin), .pwm_irq(pwm_irq));
    fcpwm_load_model i_fcpwm_load_model (.clk_sys(clk_sys), .run(run), .clear(clear),
        .pin(pwm_output_pin), .high_cnt(high_cnt));
    // Overflow pulse every 5 cycles, external input falls every 10
    always @(posedge clk_sys) begin
        t0_cnt <= (t0_cnt == 4'h4) ? 4'h0 : t0_cnt + 4'h1;
        t0_ovf <= (t0_cnt == 4'h4);
        if (t0_cnt == 4'h4)
            t0_ext <= ~t0_ext;
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Leaves the strobe up so writes can follow back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, reg_rdata});
        @(posedge clk_sys);
    endtask
    task automatic measure(input int n);
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
        run <= 1'b1;
        repeat (n) @(posedge clk_sys);
        run <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic t_reset_values();
        foreach (amap[i]) rd_chk(amap[i], (amap[i] == ADDR_MAX_LO) ? RST_MAX_LO : RST_ZERO);
        $display("test reset_values done");
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++) wr(amap[i], (i % 2 == 0) ? 8'hff : 8'ha5);
        wr(8'h00, 8'hff);
        wr(ADDR_MAX_HI, 8'h03);
        wr(ADDR_MAX_LO, 8'h5c);
        for (int i = 0; i < 8; i++) rd_chk(amap[i], (i % 2 == 0) ? 8'h83 : 8'ha5);
        rd_chk(ADDR_MAX_HI, 8'h03);
        rd_chk(ADDR_MAX_LO, 8'h5c);
        rd_chk(8'h00, 8'h00);
        wr(ADDR_CTRL, 8'hff);
        rd_chk(ADDR_CTRL, 8'hef);
        wr(ADDR_CH0_HI, 8'h7d);
        rd_chk(ADDR_CH0_HI, 8'h01);
        $display("test regs done");
    endtask
    task automatic t_wave();
        logic [15:0] exp [4] = '{16'h000a, 16'h0014, 16'h0028, 16'h0028};
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MAX_HI, 8'h00);
        wr(ADDR_MAX_LO, 8'h03);
        wr(ADDR_CH0_HI, 8'h00);
        wr(ADDR_CH0_LO, 8'h01);
        wr(ADDR_CH1_HI, 8'h80);
        wr(ADDR_CH1_LO, 8'h02);
        wr(ADDR_CH2_HI, 8'h80);
        wr(ADDR_CH2_LO, 8'h00);
        wr(ADDR_CH3_HI, 8'h01);
        wr(ADDR_CH3_LO, 8'h00);
        wr(ADDR_ROUTE, 8'h00);
        idle(4);
        chk("idle pins", 16'h0006, {12'h000, pwm_output_pin});
        wr(ADDR_CTRL, 8'h0f);
        idle(8);
        chk("port4 steady bits", 16'h0003, {14'h0000, port4_pwm[3:2]});
        measure(40);
        foreach (exp[i]) chk("high cycles", exp[i], high_cnt[i]);
        wr(ADDR_ROUTE, 8'h02);
        rd_chk(ADDR_ROUTE, 8'h02);
        idle(4);
        chk("port4 unrouted", 16'h0006, {12'h000, port4_pwm});
        chk("port2 steady bits", 16'h0003, {14'h0000, port2_pwm[3:2]});
        wr(ADDR_ROUTE, 8'h00);
        $display("test wave done");
    endtask
    task automatic t_clock_sel();
        int per [8] = '{1, 2, 4, 6, 8, 12, 5, 10};
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CTRL, {3'(c), 5'h01});
            idle(8 * per[c] + 8);
            measure(12 * per[c]);
            chk($sformatf("select %0d", c), 16'(3 * per[c]), high_cnt[0]);
        end
        $display("test clock_sel done");
    endtask
    task automatic t_irq();
        wr(ADDR_CTRL, 8'h01);
        idle(8);
        chk("irq masked", 16'h0000, {15'h0000, pwm_irq});
        rd_chk(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h01);
        rd_chk(ADDR_IRQ_MASK, 8'h01);
        idle(3);
        chk("irq raised", 16'h0001, {15'h0000, pwm_irq});
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_IRQ_STAT, 8'h01);
        idle(3);
        chk("irq cleared", 16'h0000, {15'h0000, pwm_irq});
        rd_chk(ADDR_IRQ_STAT, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h00);
        idle(1);
        $display("test irq done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset_values();
        t_regs();
        t_wave();
        t_clock_sel();
        t_irq();
        give_verdict();
    end
    // About twelve hundred cycles are needed; the margin is wide
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
